// ==== hw/timer_mode_counter_defines.svh ====
// Function
// - 8-bit counter behind 16-bit prescaler
// - Control bit 7 low selects timer; high stops count, output low
// - Counter increments on each prescaler output tick
// - Count readable at counter index 18, or the held capture while stopped
// - Status index 19: bit1 running, bit0 set
// - Clock, clear, start each internal or pin
// - Prescaler fed by master clock or pin
// - Divider field selects prescaler ratio
// - Clear signal holds counter at zero
// - Start/stop gates counting in timer mode only
// - Pin start is level or edge sensitive
// - Level: count while high, capture on low
// - Edge: first rise starts, next rise stops
// - Output rate is tick rate over compare
// - Square waveform high for half the compare count, rounded up
// - Pulse waveform: one tick-long pulse per cycle
// - Pins used only when configured as inputs
// - Output and complement on enabled pins
// - Source field codes; bit4 clock; bit5 zero
// - Divider code doubles ratio; bit5 waveform
// - Control bits: clear, run, edge, mode
`ifndef TIMER_MODE_COUNTER_DEFINES_SVH
`define TIMER_MODE_COUNTER_DEFINES_SVH
`define TMC_IDX_PIN_CFG 8'h04
`define TMC_IDX_CTRL 8'h05
`define TMC_IDX_DIV 8'h06
`define TMC_IDX_SRC 8'h07
`define TMC_IDX_CMP 8'h09
`define TMC_IDX_COUNT 8'h12
`define TMC_IDX_STATE 8'h13
`define TMC_CTRL_CLR_BIT 0
`define TMC_CTRL_RUN_BIT 2
`define TMC_CTRL_EDGE_BIT 3
`define TMC_CTRL_MODE_BIT 7
`define TMC_DIV_WAVE_BIT 5
`define TMC_SRC_CLK_BIT 4
`define TMC_PIN_START_IN 0
`define TMC_PIN_CLEAR_IN 1
`define TMC_PIN_CLK_IN 2
`define TMC_PIN_OUT_EN 3
`define TMC_PIN_OUTN_EN 4
`define TMC_DIV_MAX 5'h10
`define TMC_REG_RST 8'h00
`define TMC_CTRL_WMASK 8'h8D
`define TMC_DIV_WMASK 8'h3F
`define TMC_SRC_WMASK 8'h1F
`define TMC_PIN_WMASK 8'h1F
`define TMC_RESP_OKAY 2'b00
`define TMC_RESP_SLVERR 2'b10
`endif

// ==== hw/timer_mode_counter_pkg.sv ====
package timer_mode_counter_pkg;
    typedef enum logic [1:0] {
        SRC_INT = 2'b00,
        SRC_EXT = 2'b01,
        SRC_ANY = 2'b10,
        SRC_NONE = 2'b11
    } src_sel_t;
    typedef enum logic [2:0] {
        EDGE_WAIT = 3'b001,
        EDGE_RUN = 3'b010,
        EDGE_DONE = 3'b100
    } edge_state_t;
endpackage

// ==== hw/timer_mode_counter.sv ====
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "timer_mode_counter_defines.svh"
module timer_mode_counter
    import timer_mode_counter_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic i_start_stop_input,
    input wire logic i_counter_clear_input,
    input wire logic i_external_count_clock_pin,
    output logic o_timer_output_pin,
    output logic o_timer_output_pin_oe,
    output logic o_timer_output_inverted_pin,
    output logic o_timer_output_inverted_pin_oe
);

    // Prescaler ratio 2^code as a low-bit mask; codes past the top saturate
    function automatic logic [15:0] div_mask(input logic [4:0] code);
        logic [4:0] c;
        c = (code > `TMC_DIV_MAX) ? `TMC_DIV_MAX : code;
        div_mask = 16'((17'h0_0001 << c) - 17'h0_0001);
    endfunction

    // Compare of zero counts a full 256
    function automatic logic [8:0] eff_cmp(input logic [7:0] v);
        eff_cmp = (v == 8'h00) ? 9'h100 : {1'b0, v};
    endfunction

    logic [7:0] timer_control_register_q;
    logic [7:0] divider_waveform_register_q;
    logic [7:0] source_select_register_q;
    logic [7:0] pin_config_q;
    logic [7:0] compare_value_out_q;

    // Pin synchronisers and edge history
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [2:0] pin_prev_q;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_meta_q <= 3'b000;
            pin_sync_q <= 3'b000;
            pin_prev_q <= 3'b000;
        end else begin
            pin_meta_q <= {i_external_count_clock_pin, i_counter_clear_input,
                i_start_stop_input};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic start_en, clear_en, clk_en;
    assign start_en = pin_config_q[`TMC_PIN_START_IN];
    assign clear_en = pin_config_q[`TMC_PIN_CLEAR_IN];
    assign clk_en = pin_config_q[`TMC_PIN_CLK_IN];

    logic start_s, start_rise, start_fall, clear_s, clk_rise;
    assign start_s = pin_sync_q[0] & start_en;
    assign start_rise = start_en & pin_sync_q[0] & ~pin_prev_q[0];
    assign start_fall = start_en & ~pin_sync_q[0] & pin_prev_q[0];
    assign clear_s = pin_sync_q[1] & clear_en;
    assign clk_rise = clk_en & pin_sync_q[2] & ~pin_prev_q[2];

    src_sel_t clr_src, run_src;
    assign clr_src = src_sel_t'(source_select_register_q[1:0]);
    assign run_src = src_sel_t'(source_select_register_q[3:2]);

    logic timer_mode, edge_mode, wave_square, ext_clk;
    assign timer_mode = ~timer_control_register_q[`TMC_CTRL_MODE_BIT];
    assign edge_mode = timer_control_register_q[`TMC_CTRL_EDGE_BIT];
    assign wave_square = divider_waveform_register_q[`TMC_DIV_WAVE_BIT];
    assign ext_clk = source_select_register_q[`TMC_SRC_CLK_BIT];

    // Internal clear is active while the set bit is low
    logic int_clear, clear_act;
    assign int_clear = ~timer_control_register_q[`TMC_CTRL_CLR_BIT];
    always_comb begin
        case (clr_src)
            SRC_INT: clear_act = int_clear;
            SRC_EXT: clear_act = clear_s;
            SRC_ANY: clear_act = int_clear | clear_s;
            default: clear_act = 1'b0;
        endcase
    end

    edge_state_t edge_q;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            edge_q <= EDGE_WAIT;
        end else if (clear_act || !edge_mode) begin
            edge_q <= EDGE_WAIT;
        end else begin
            case (edge_q)
                EDGE_WAIT: if (start_rise) edge_q <= EDGE_RUN;
                EDGE_RUN: if (start_rise) edge_q <= EDGE_DONE;
                EDGE_DONE: edge_q <= EDGE_DONE;
                default: edge_q <= EDGE_WAIT;
            endcase
        end
    end

    logic ext_run, int_run, run_sel, run_act;
    assign ext_run = edge_mode ? (edge_q == EDGE_RUN) : start_s;
    assign int_run = timer_control_register_q[`TMC_CTRL_RUN_BIT];
    always_comb begin
        case (run_src)
            SRC_INT: run_sel = int_run;
            SRC_EXT: run_sel = ext_run;
            SRC_ANY: run_sel = int_run | ext_run;
            default: run_sel = 1'b0;
        endcase
    end
    assign run_act = run_sel & timer_mode & ~clear_act;

    // Prescaler; source tick is every master cycle or a pin rising edge
    logic src_tick, div_tick;
    logic [15:0] div_cnt_q;
    logic [15:0] mask;
    assign src_tick = ext_clk ? clk_rise : 1'b1;
    assign mask = div_mask(divider_waveform_register_q[4:0]);
    assign div_tick = src_tick & ((div_cnt_q & mask) == mask);
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_cnt_q <= 16'h0000;
        end else if (clear_act) begin
            div_cnt_q <= 16'h0000;
        end else if (src_tick) begin
            div_cnt_q <= div_cnt_q + 16'h0001;
        end
    end

    // Compare applied from the next wrap or clear onward
    logic [7:0] cmp_act_q;
    logic [7:0] cnt_q;
    logic [7:0] last;
    logic [8:0] half;
    logic wrap;
    assign last = 8'(eff_cmp(cmp_act_q) - 9'h001);
    assign half = (eff_cmp(cmp_act_q) + 9'h001) >> 1;
    assign wrap = run_act & div_tick & (cnt_q == last);
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 8'h00;
            cmp_act_q <= 8'h00;
        end else if (clear_act) begin
            cnt_q <= 8'h00;
            cmp_act_q <= compare_value_out_q;
        end else if (wrap) begin
            cnt_q <= 8'h00;
            cmp_act_q <= compare_value_out_q;
        end else if (run_act && div_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Capture on the stopping edge of an external start
    logic cap_ev, cap_vld_q, run_prev_q;
    logic [7:0] cap_q;
    assign cap_ev = (run_src != SRC_INT) & ~clear_act &
        (edge_mode ? (edge_q == EDGE_RUN && start_rise) : start_fall);
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cap_q <= 8'h00;
            cap_vld_q <= 1'b0;
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_act;
            if (cap_ev) begin
                cap_q <= cnt_q;
                cap_vld_q <= 1'b1;
            end else if (clear_act || (run_act && !run_prev_q)) begin
                cap_vld_q <= 1'b0;
            end
        end
    end

    // Output waveform, tristated while held in clear
    logic out_d;
    always_comb begin
        if (!timer_mode) begin
            out_d = 1'b0;
        end else if (wave_square) begin
            out_d = ({1'b0, cnt_q} < half);
        end else begin
            out_d = run_sel & (cnt_q == last);
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_timer_output_pin <= 1'b0;
            o_timer_output_inverted_pin <= 1'b1;
            o_timer_output_pin_oe <= 1'b0;
            o_timer_output_inverted_pin_oe <= 1'b0;
        end else begin
            o_timer_output_pin <= out_d;
            o_timer_output_inverted_pin <= ~out_d;
            o_timer_output_pin_oe <= ~clear_act & pin_config_q[`TMC_PIN_OUT_EN];
            o_timer_output_inverted_pin_oe <= ~clear_act &
                pin_config_q[`TMC_PIN_OUTN_EN];
        end
    end

    // AXI4-Lite slave: one write and one read outstanding
    logic aw_got_q, w_got_q, wr_fire;
    logic [7:0] aw_idx_q;
    logic [7:0] wdat_q;
    logic wstrb0_q;
    assign wr_fire = aw_got_q & w_got_q & ~o_bvalid;
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_idx_q <= 8'h00;
            wdat_q <= 8'h00;
            wstrb0_q <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= `TMC_RESP_OKAY;
        end else begin
            if (o_awready && i_awvalid) begin
                aw_idx_q <= i_awaddr[9:2];
                aw_got_q <= 1'b1;
                o_awready <= 1'b0;
            end
            if (o_wready && i_wvalid) begin
                wdat_q <= i_wdata[7:0];
                wstrb0_q <= i_wstrb[0];
                w_got_q <= 1'b1;
                o_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (aw_idx_q == `TMC_IDX_CTRL || aw_idx_q == `TMC_IDX_DIV ||
                    aw_idx_q == `TMC_IDX_SRC || aw_idx_q == `TMC_IDX_CMP ||
                    aw_idx_q == `TMC_IDX_PIN_CFG) ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            timer_control_register_q <= `TMC_REG_RST;
            divider_waveform_register_q <= `TMC_REG_RST;
            source_select_register_q <= `TMC_REG_RST;
            pin_config_q <= `TMC_REG_RST;
            compare_value_out_q <= `TMC_REG_RST;
        end else if (wr_fire && wstrb0_q) begin
            case (aw_idx_q)
                `TMC_IDX_CTRL: timer_control_register_q <= wdat_q & `TMC_CTRL_WMASK;
                `TMC_IDX_DIV: divider_waveform_register_q <= wdat_q & `TMC_DIV_WMASK;
                `TMC_IDX_SRC: source_select_register_q <= wdat_q & `TMC_SRC_WMASK;
                `TMC_IDX_PIN_CFG: pin_config_q <= wdat_q & `TMC_PIN_WMASK;
                `TMC_IDX_CMP: compare_value_out_q <= wdat_q;
                default: compare_value_out_q <= compare_value_out_q;
            endcase
        end
    end

    logic [7:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (i_araddr[9:2])
            `TMC_IDX_CTRL: rd_val = timer_control_register_q;
            `TMC_IDX_DIV: rd_val = divider_waveform_register_q;
            `TMC_IDX_SRC: rd_val = source_select_register_q;
            `TMC_IDX_PIN_CFG: rd_val = pin_config_q;
            `TMC_IDX_CMP: rd_val = 8'h00;
            `TMC_IDX_COUNT: rd_val = (cap_vld_q && !run_act) ? cap_q : cnt_q;
            `TMC_IDX_STATE: rd_val = {6'h00, run_act, ~clear_act};
            default: begin
                rd_val = 8'h00;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `TMC_RESP_OKAY;
        end else if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= {24'h00_0000, rd_val};
            o_rresp <= rd_ok ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_clear_zero;
        clear_act |=> (cnt_q == 8'h00);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("count not cleared");

    property p_count_step;
        (run_act && div_tick && !wrap) |=> (cnt_q == $past(cnt_q) + 8'h01);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count did not step");

    property p_wrap_zero;
        wrap |=> (cnt_q == 8'h00);
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("count did not wrap");

    property p_hold_stopped;
        (!run_act && !clear_act) |=> $stable(cnt_q);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("count moved stopped");

    property p_level_capture;
        (!edge_mode && cap_ev) |=> (cap_q == $past(cnt_q)) && cap_vld_q;
    endproperty
    a_level_capture: assert property (p_level_capture) else $error("capture lost");

    sequence s_first_rise;
        edge_mode && !clear_act && (edge_q == EDGE_WAIT) && start_rise;
    endsequence
    sequence s_second_rise;
        edge_mode && !clear_act && (edge_q == EDGE_RUN) && start_rise;
    endsequence
    property p_edge_measure;
        s_first_rise ##1 (edge_q == EDGE_RUN && !clear_act && !start_rise) [*2]
            |=> (edge_q == EDGE_RUN);
    endproperty
    a_edge_measure: assert property (p_edge_measure) else $error("edge run lost");

    property p_edge_stop;
        s_second_rise |=> (edge_q == EDGE_DONE) ##1 (edge_q == EDGE_DONE || clear_act ||
            !edge_mode);
    endproperty
    a_edge_stop: assert property (p_edge_stop) else $error("edge stop missed");

    property p_pulse_out;
        (timer_mode && !wave_square && run_sel && cnt_q == last) |=> o_timer_output_pin;
    endproperty
    a_pulse_out: assert property (p_pulse_out) else $error("pulse missing");

    property p_square_out;
        (timer_mode && wave_square) |=> (o_timer_output_pin == ($past({1'b0, cnt_q}) <
            $past(half)));
    endproperty
    a_square_out: assert property (p_square_out) else $error("square wrong");

    property p_complement;
        o_timer_output_inverted_pin == !o_timer_output_pin;
    endproperty
    a_complement: assert property (p_complement) else $error("complement wrong");

    property p_div_one;
        (!ext_clk && divider_waveform_register_q[4:0] == 5'h00) |-> div_tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one failed");

    property p_pin_ignored;
        (!clk_en && ext_clk) |-> !div_tick;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored) else $error("clock pin not gated");

endmodule

// ==== verification/ext_signal_source.sv ====
`timescale 1ns/10ps
module ext_signal_source (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic [7:0] i_half,
    input wire logic i_start_lvl,
    input wire logic i_clear_lvl,
    output logic o_start,
    output logic o_clear,
    output logic o_ext_clk
);
    logic [7:0] cnt_q;
    logic [7:0] half;
    // Never faster than a quarter of the system clock
    assign half = (i_half < 8'h02) ? 8'h02 : i_half;
    // Clock stands low while not enabled
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 8'h00;
            o_ext_clk <= 1'b0;
        end else if (!i_clk_en) begin
            cnt_q <= 8'h00;
            o_ext_clk <= 1'b0;
        end else if (cnt_q >= half - 8'h01) begin
            cnt_q <= 8'h00;
            o_ext_clk <= ~o_ext_clk;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_start <= 1'b0;
            o_clear <= 1'b0;
        end else begin
            o_start <= i_start_lvl;
            o_clear <= i_clear_lvl;
        end
    end
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`include "timer_mode_counter_defines.svh"
module testbench
    import timer_mode_counter_pkg::*;
;
    localparam logic [7:0] PIN = `TMC_IDX_PIN_CFG;
    localparam logic [7:0] CTRL = `TMC_IDX_CTRL;
    localparam logic [7:0] DIV = `TMC_IDX_DIV;
    localparam logic [7:0] SRC = `TMC_IDX_SRC;
    localparam logic [7:0] CMP = `TMC_IDX_CMP;
    localparam logic [7:0] CNT = `TMC_IDX_COUNT;
    localparam logic [7:0] STA = `TMC_IDX_STATE;
    localparam logic [1:0] OK = `TMC_RESP_OKAY;
    localparam logic [1:0] ERR = `TMC_RESP_SLVERR;
    logic sys_clk, arst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [3:0] wstrb;
    logic [1:0] rs;
    logic clk_en, start_lvl, clear_lvl;
    logic [7:0] half;
    logic [7:0] idx_tab [7] = '{PIN, CTRL, DIV, SRC, CMP, CNT, STA};
    logic [7:0] msk_tab [3] = '{8'h8D, 8'h3F, 8'h1F};
    wire logic awready, wready, bvalid, arready, rvalid, start_pin, clear_pin, ext_clk;
    wire logic pin_out, pin_out_oe, pin_out_n, pin_out_n_oe;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    int seed, hi, per, a, b, k;

    timer_mode_counter u_timer_mode_counter (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_start_stop_input(start_pin), .i_counter_clear_input(clear_pin),
        .i_external_count_clock_pin(ext_clk), .o_timer_output_pin(pin_out),
        .o_timer_output_pin_oe(pin_out_oe), .o_timer_output_inverted_pin(pin_out_n),
        .o_timer_output_inverted_pin_oe(pin_out_n_oe));
    ext_signal_source u_ext_signal_source (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
        .i_clk_en(clk_en), .i_half(half), .i_start_lvl(start_lvl), .i_clear_lvl(clear_lvl),
        .o_start(start_pin), .o_clear(clear_pin), .o_ext_clk(ext_clk));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        int t;
        @(posedge sys_clk);
        awaddr <= {2'b00, idx, 2'b00};
        wdata <= ($random(seed) & 32'hffff_ff00) | {24'h00_0000, d};
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        t = 0;
        forever begin
            @(posedge sys_clk);
            if (!aw && !w && bvalid) break;
            if (aw && awready) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
            if (++t > 100) begin
                n_fail++;
                stop_test();
            end
        end
        bready <= 1'b0;
        cmp_resp(bresp, er);
    endtask
    task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic pend;
        int t;
        @(posedge sys_clk);
        araddr <= {2'b00, idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        pend = 1'b1;
        t = 0;
        forever begin
            @(posedge sys_clk);
            if (!pend && rvalid) break;
            if (pend && arready) begin
                pend = 1'b0;
                arvalid <= 1'b0;
            end
            if (++t > 100) begin
                n_fail++;
                stop_test();
            end
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        rd_reg(idx, rd, rs);
        cmp_data(rd, ed);
        cmp_resp(rs, er);
    endtask
    // Cycles high, then cycles of one full output period
    task automatic meas(output int h, output int p);
        int t;
        t = 0;
        h = 0;
        while (pin_out !== 1'b0 && t < 3000) begin
            @(posedge sys_clk);
            t++;
        end
        while (pin_out !== 1'b1 && t < 3000) begin
            @(posedge sys_clk);
            t++;
        end
        while (pin_out === 1'b1 && t < 3000) begin
            @(posedge sys_clk);
            h++;
            t++;
        end
        p = h;
        while (pin_out === 1'b0 && t < 3000) begin
            @(posedge sys_clk);
            p++;
            t++;
        end
    endtask
    task automatic pulse(input int n);
        start_lvl <= 1'b1;
        repeat (n) @(posedge sys_clk);
        start_lvl <= 1'b0;
    endtask
    function automatic int exp_per(input int c, input int dv);
        return ((c == 0) ? 256 : c) << dv;
    endfunction
    function automatic int exp_hi(input int c, input int dv, input int sq);
        return sq ? exp_per(c, dv) / 2 : (1 << dv);
    endfunction

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        seed = 28216;
        {arst_n, awvalid, wvalid, bready, arvalid, rready, clk_en, start_lvl, clear_lvl} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        half = 8'h04;
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (k = 0; k < 7; k++) rchk(idx_tab[k], 0, OK);
        rchk(8'h20, 0, ERR);
        wr(CNT, 8'h55, ERR);
        for (k = 0; k < 3; k++) begin
            wr(idx_tab[k + 1], 8'hFF, OK);
            rchk(idx_tab[k + 1], {24'h00_0000, msk_tab[k]}, OK);
            wr(idx_tab[k + 1], 8'h00, OK);
        end
        wr(CMP, 8'h04, OK);
        wr(CTRL, 8'h05, OK);
        repeat (4) @(posedge sys_clk);
        cmp_data({30'h0, pin_out_oe, pin_out_n_oe}, 0);
        wr(PIN, 8'h18, OK);
        rchk(STA, 3, OK);
        meas(hi, per);
        meas(hi, per);
        cmp_data(32'(per), 4);
        cmp_data(32'(hi), 1);
        cmp_data({29'h0, pin_out_oe, pin_out_n_oe, pin_out_n ^ pin_out}, 7);
        for (k = 0; k < 6; k++) begin
            a = 2 * (1 + ($random(seed) & 7));
            b = $random(seed) & 3;
            wr(DIV, 8'(b | ((k & 1) << 5)), OK);
            wr(CMP, 8'(a), OK);
            meas(hi, per);
            meas(hi, per);
            cmp_data(32'(per), 32'(exp_per(a, b)));
            cmp_data(32'(hi), 32'(exp_hi(a, b, k & 1)));
        end
        wr(DIV, 8'h08, OK);
        wr(CMP, 8'h00, OK);
        // Clear loads the new compare at once, so no early wrap spoils the delta
        wr(CTRL, 8'h04, OK);
        wr(CTRL, 8'h05, OK);
        rd_reg(CNT, rd, rs);
        a = int'(rd[7:0]);
        repeat (768) @(posedge sys_clk);
        rd_reg(CNT, rd, rs);
        cmp_data(32'(((int'(rd[7:0]) - a) & 255) inside {[3:4]}), 1);
        wr(CTRL, 8'h01, OK);
        rchk(STA, 1, OK);
        rd_reg(CNT, rd, rs);
        repeat (600) @(posedge sys_clk);
        rchk(CNT, rd, OK);
        wr(CTRL, 8'h05, OK);
        wr(CTRL, 8'h85, OK);
        rd_reg(CNT, rd, rs);
        repeat (600) @(posedge sys_clk);
        rchk(CNT, rd, OK);
        wr(CTRL, 8'h04, OK);
        rchk(CNT, 0, OK);
        cmp_data({31'h0, pin_out_oe}, 0);
        wr(DIV, 8'h00, OK);
        wr(SRC, 8'h04, OK);
        wr(CTRL, 8'h01, OK);
        pulse(20);
        repeat (8) @(posedge sys_clk);
        rchk(CNT, 0, OK);
        wr(PIN, 8'h19, OK);
        a = 40 + ($random(seed) & 31);
        pulse(a);
        repeat (8) @(posedge sys_clk);
        rd_reg(CNT, rd, rs);
        cmp_data(32'(int'(rd) inside {[a - 1:a + 1]}), 1);
        rchk(STA, 1, OK);
        wr(CTRL, 8'h00, OK);
        wr(CTRL, 8'h09, OK);
        pulse(5);
        repeat (55) @(posedge sys_clk);
        pulse(5);
        repeat (8) @(posedge sys_clk);
        rd_reg(CNT, rd, rs);
        cmp_data(32'(int'(rd) inside {[59:61]}), 1);
        pulse(5);
        repeat (40) @(posedge sys_clk);
        rchk(CNT, rd, OK);
        wr(SRC, 8'h0A, OK);
        wr(PIN, 8'h1A, OK);
        wr(CTRL, 8'h05, OK);
        repeat (20) @(posedge sys_clk);
        clear_lvl <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rchk(CNT, 0, OK);
        clear_lvl <= 1'b0;
        wr(SRC, 8'h10, OK);
        wr(PIN, 8'h1C, OK);
        wr(CMP, 8'h04, OK);
        clk_en <= 1'b1;
        meas(hi, per);
        meas(hi, per);
        cmp_data(32'(per), 32'(exp_per(4, 3)));
        cmp_data(32'(hi), 32'(exp_hi(4, 3, 0)));
        stop_test();
    end
endmodule
